// file: hw/ptbc_cfg.svh
// Register map, field positions and reset values of the PWM time base control block.
`ifndef PTBC_CFG_SVH
`define PTBC_CFG_SVH

// Register word addresses.
`define PTBC_ADDR_CTRL 4'h0
`define PTBC_ADDR_DIV 4'h1
`define PTBC_ADDR_STAT 4'h2
`define PTBC_ADDR_MASK 4'h3
`define PTBC_ADDR_PER 4'h4
`define PTBC_ADDR_SEV 4'h5
`define PTBC_ADDR_CNT 4'h6

// Control register fields.
`define PTBC_B_EN 15
`define PTBC_B_IDLE 13
`define PTBC_B_PEND 12
`define PTBC_B_SPECIAL_EVENT_IRQ_ENABLE 11
`define PTBC_B_IMM 10
`define PTBC_B_POL 9
`define PTBC_B_SOEN 8
`define PTBC_B_EXTERNAL_SYNC_ENABLE 7
`define PTBC_CTRL_WMASK 16'hAF80
`define PTBC_CTRL_RST 16'h0000

// Divider register.
`define PTBC_DIV_W 3
`define PTBC_DIV_RST 3'h0
`define PTBC_DIV_RSVD 3'h7

// Interrupt status and mask bits.
`define PTBC_IRQ_W 3
`define PTBC_IRQ_BOUND 0
`define PTBC_IRQ_SEV 1
`define PTBC_IRQ_SYNC 2

`endif

// file: hw/ptbc_pkg.sv
// State types of the PWM time base control block.
package ptbc_pkg;

    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } ptbc_pres_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic pulse;
    } ptbc_sync_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [2:0] clk_div;
        logic [15:0] period_buf;
        logic [15:0] period_act;
        logic [15:0] sev_cmp;
        logic [15:0] count;
        logic pending;
        logic [2:0] status;
        logic [2:0] mask;
        logic [15:0] rdata;
        logic irq;
        logic se_irq;
        logic sync_out;
        logic sync_oe;
        logic boundary;
    } ptbc_state_t;

endpackage : ptbc_pkg

// file: hw/ptbc_prescaler.sv
// Input clock divider that issues one-cycle count enables for the time base.
`timescale 1ns/100ps
`default_nettype none
`include "ptbc_cfg.svh"
module ptbc_prescaler (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Control.
    input wire logic run_in,
    input wire logic [2:0] code_in,
    // Enable pulse.
    output logic tick_out
);
    ptbc_pkg::ptbc_pres_t q;
    ptbc_pkg::ptbc_pres_t next_q;
    logic [6:0] span;
    logic [5:0] limit;

    always_comb begin
        span = 7'h01 << code_in;
        limit = span[5:0] - 6'h01;
        next_q = q;
        next_q.tick = 1'b0;
        // The reserved code stops the enables rather than guess a ratio.
        if (!run_in || code_in == `PTBC_DIV_RSVD) begin
            next_q.cnt = 6'h00;
        end else if (q.cnt == limit) begin
            next_q.cnt = 6'h00;
            next_q.tick = 1'b1;
        end else begin
            next_q.cnt = q.cnt + 6'h01;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign tick_out = q.tick;

    div_two_gap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (code_in == 3'h1 && run_in && $stable(code_in)) ##0 tick_out |=> !tick_out)
        else $error("Divide-by-2 produced back-to-back enables.");
endmodule : ptbc_prescaler
`default_nettype wire

// file: hw/ptbc_sync_in.sv
// Synchroniser and active-edge detector for the external sync input pin.
`timescale 1ns/100ps
`default_nettype none
module ptbc_sync_in (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Pin and polarity.
    input wire logic pin_in,
    input wire logic polarity_in,
    // One-cycle pulse on the active edge.
    output logic pulse_out
);
    ptbc_pkg::ptbc_sync_t q;
    ptbc_pkg::ptbc_sync_t next_q;
    logic active;

    always_comb begin
        next_q = q;
        next_q.s1 = pin_in;
        next_q.s2 = q.s1;
        active = q.s2 ^ polarity_in;
        next_q.prev = active;
        next_q.pulse = active & ~q.prev;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign pulse_out = q.pulse;
endmodule : ptbc_sync_in
`default_nettype wire

// file: hw/ptbc_top.sv
// Primary PWM time base: registers, divider, period count, sync and special event logic.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "ptbc_cfg.svh"
module ptbc_top (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Register port.
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // System status and acknowledge.
    input wire logic cpu_idle_in,
    input wire logic se_ack_in,
    // External sync pins.
    input wire logic sync_input_in,
    output logic sync_output_out,
    output logic sync_output_oe_out,
    // Time base outputs.
    output logic cycle_start_out,
    output logic module_enable_out,
    output logic [15:0] count_out,
    // Interrupts.
    output logic irq_out,
    output logic se_irq_out
);
    ptbc_pkg::ptbc_state_t q;
    ptbc_pkg::ptbc_state_t next_q;

    logic tick;
    logic sync_pulse;
    logic module_enable;
    logic idle_stop;
    logic immediate_period_update;
    logic sync_polarity;
    logic sync_output_enable;
    logic external_sync_enable;
    logic running;
    logic restart;
    logic wrap;
    logic sev_hit;
    logic [2:0] events;
    logic [15:0] read_value;

    assign module_enable = q.ctrl[`PTBC_B_EN];
    assign idle_stop = q.ctrl[`PTBC_B_IDLE];
    assign immediate_period_update = q.ctrl[`PTBC_B_IMM];
    assign sync_polarity = q.ctrl[`PTBC_B_POL];
    assign sync_output_enable = q.ctrl[`PTBC_B_SOEN];
    assign external_sync_enable = q.ctrl[`PTBC_B_EXTERNAL_SYNC_ENABLE];

    // Idle stop freezes the count but clears the divider to zero, so the divider phase is lost.
    assign running = module_enable && !(idle_stop && cpu_idle_in);

    ptbc_prescaler u_prescaler (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .run_in(running),
        .code_in(q.clk_div),
        .tick_out(tick)
    );

    ptbc_sync_in u_sync_in (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(sync_input_in),
        .polarity_in(sync_polarity),
        .pulse_out(sync_pulse)
    );

    // An external sync edge restarts the period at once, independent of the divider.
    // This only works cleanly if the programmed period outlasts the incoming one.
    assign restart = module_enable && external_sync_enable && sync_pulse;
    assign wrap = running && tick && (q.count >= q.period_act);
    assign sev_hit = running && tick && (q.count == q.sev_cmp);
    assign events = {restart, sev_hit, restart | wrap};

    always_comb begin
        read_value = 16'h0000;
        unique case (addr_in)
            `PTBC_ADDR_CTRL: begin
                read_value = q.ctrl & `PTBC_CTRL_WMASK;
                read_value[`PTBC_B_PEND] = q.pending;
            end
            `PTBC_ADDR_DIV: read_value = {13'h0000, q.clk_div};
            `PTBC_ADDR_STAT: read_value = {13'h0000, q.status};
            `PTBC_ADDR_MASK: read_value = {13'h0000, q.mask};
            `PTBC_ADDR_PER: read_value = q.period_buf;
            `PTBC_ADDR_SEV: read_value = q.sev_cmp;
            `PTBC_ADDR_CNT: read_value = q.count;
            default: read_value = 16'h0000;
        endcase
    end

    always_comb begin
        next_q = q;
        next_q.rdata = rd_in ? read_value : 16'h0000;
        next_q.boundary = 1'b0;

        // Register writes; the pending bit is not software storage.
        if (wr_in) begin
            unique case (addr_in)
                `PTBC_ADDR_CTRL: next_q.ctrl = wdata_in & `PTBC_CTRL_WMASK;
                `PTBC_ADDR_DIV: next_q.clk_div = wdata_in[2:0];
                `PTBC_ADDR_MASK: next_q.mask = wdata_in[2:0];
                `PTBC_ADDR_PER: next_q.period_buf = wdata_in;
                `PTBC_ADDR_SEV: next_q.sev_cmp = wdata_in;
                default: next_q.ctrl = q.ctrl;
            endcase
        end

        // Period count.
        if (!module_enable) begin
            next_q.count = 16'h0000;
            next_q.period_act = q.period_buf;
        end else begin
            if (restart || wrap) begin
                next_q.count = 16'h0000;
                next_q.boundary = 1'b1;
                next_q.period_act = q.period_buf;
            end else if (running && tick) begin
                next_q.count = q.count + 16'h0001;
            end
            if (immediate_period_update) begin
                next_q.period_act = q.period_buf;
            end
        end

        // Hardware clears the pending flag on acknowledge; a new hit wins.
        if (se_ack_in) begin
            next_q.pending = 1'b0;
        end
        if (sev_hit) begin
            next_q.pending = 1'b1;
        end

        // Sticky status cleared by its read; a same-cycle event stays set.
        if (rd_in && addr_in == `PTBC_ADDR_STAT) begin
            next_q.status = 3'h0;
        end
        next_q.status = next_q.status | events;

        next_q.irq = |(q.status & q.mask);
        next_q.se_irq = q.pending && q.ctrl[`PTBC_B_SPECIAL_EVENT_IRQ_ENABLE];

        // Sync output pulses one cycle per boundary; idle level follows polarity.
        next_q.sync_oe = sync_output_enable;
        next_q.sync_out = (sync_output_enable && (restart || wrap)) ^ sync_polarity;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign rdata_out = q.rdata;
    assign sync_output_out = q.sync_out;
    assign sync_output_oe_out = q.sync_oe;
    assign cycle_start_out = q.boundary;
    assign module_enable_out = q.ctrl[`PTBC_B_EN];
    assign count_out = q.count;
    assign irq_out = q.irq;
    assign se_irq_out = q.se_irq;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence period_write_s;
        wr_in && addr_in == `PTBC_ADDR_PER && module_enable && immediate_period_update;
    endsequence

    sequence ctrl_read_s;
        rd_in && addr_in == `PTBC_ADDR_CTRL;
    endsequence

    sequence div_read_s;
        rd_in && addr_in == `PTBC_ADDR_DIV;
    endsequence

    disabled_hold_a: assert property (!module_enable |=> count_out == 16'h0000)
        else $error("Count moved while the module was disabled.");

    idle_halt_a: assert property (
        (module_enable && idle_stop && cpu_idle_in && !restart && !(wr_in && addr_in == `PTBC_ADDR_CTRL))
        |=> $stable(count_out))
        else $error("Time base advanced during CPU idle with idle stop set.");

    pend_read_a: assert property (ctrl_read_s |=> rdata_out[`PTBC_B_PEND] == $past(q.pending))
        else $error("Control read does not show the pending flag.");

    se_irq_gate_a: assert property (se_irq_out |-> $past(q.pending && q.ctrl[`PTBC_B_SPECIAL_EVENT_IRQ_ENABLE]))
        else $error("Special event request raised without pending and enable.");

    se_irq_raise_a: assert property (
        (q.pending && q.ctrl[`PTBC_B_SPECIAL_EVENT_IRQ_ENABLE]) |=> se_irq_out)
        else $error("Special event request missing while pending and enabled.");

    imm_update_a: assert property (
        period_write_s ##1 (module_enable && immediate_period_update)
        |=> q.period_act == $past(wdata_in, 2))
        else $error("Immediate period update did not reach the active period.");

    wait_boundary_a: assert property (
        (module_enable && !immediate_period_update && !restart && !wrap)
        |=> $stable(q.period_act))
        else $error("Active period changed away from a cycle boundary.");

    sync_pol_a: assert property (!q.sync_oe |-> sync_output_out == $past(sync_polarity))
        else $error("Disabled sync output not at its inactive level.");

    sync_oe_a: assert property (sync_output_oe_out == $past(sync_output_enable))
        else $error("Sync output enable does not follow its control bit.");

    ext_sync_a: assert property (restart |=> count_out == 16'h0000 && cycle_start_out)
        else $error("External sync edge did not restart the time base.");

    div_zero_a: assert property (div_read_s |=> rdata_out[15:3] == 13'h0000)
        else $error("Unimplemented divider bits read nonzero.");

    pend_set_a: assert property (sev_hit |=> q.pending)
        else $error("Special event hit did not set the pending flag.");

    stat_sticky_a: assert property ((rd_in && addr_in == `PTBC_ADDR_STAT && events != 3'h0)
        |=> (q.status & $past(events)) == $past(events))
        else $error("Status event lost against a clearing read.");
endmodule : ptbc_top
`default_nettype wire

// file: bench/ptbc_sync_partner.sv
// External sync source and sync output consumer at the far side of the time base.
`timescale 1ns/100ps
`default_nettype none
module ptbc_sync_partner (
    // Clock and control from the bench.
    input wire logic ref_clk_in,
    input wire logic fire_in,
    input wire logic polarity_in,
    // Sync output pins of the device.
    input wire logic sync_output_in,
    input wire logic sync_output_oe_in,
    // Sync input pin and count of seen output pulses.
    output logic sync_pin_out,
    output logic [15:0] pulses_out
);
    int hold = 0;
    initial begin
        sync_pin_out = 1'b0;
        pulses_out = 16'h0000;
    end
    always @(posedge ref_clk_in) begin
        if (fire_in) begin
            hold <= 4;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
        // The pin idles at the inactive level, so only a fire makes an active edge.
        sync_pin_out <= (fire_in || hold > 1) ? !polarity_in : polarity_in;
        if (sync_output_oe_in && sync_output_in != polarity_in) begin
            pulses_out <= pulses_out + 16'h0001;
        end
    end
endmodule : ptbc_sync_partner
`default_nettype wire

// file: bench/ptbc_tb_top.sv
// Self-checking bench for the PWM time base control block.
`timescale 1ns/100ps
`default_nettype none
`include "ptbc_cfg.svh"
module ptbc_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic idle = 1'b0;
    logic ack = 1'b0;
    logic fire = 1'b0;
    logic pol = 1'b0;
    logic pin, so, soe, cs, men, irq, se_irq;
    logic [15:0] rdata, cnt, pulses, v, p0, ctrl_m;
    logic [31:0] seed = 32'hF141;
    int num_errors = 0;
    int total_checks = 0;
    int starts = 0;
    int n, p, k, s0;
    always #20 clk = ~clk;
    always @(posedge clk) if (cs === 1'b1) starts <= starts + 1;
    ptbc_top DUT (.ref_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .cpu_idle_in(idle), .se_ack_in(ack),
        .sync_input_in(pin), .sync_output_out(so), .sync_output_oe_out(soe),
        .cycle_start_out(cs), .module_enable_out(men), .count_out(cnt), .irq_out(irq),
        .se_irq_out(se_irq));
    ptbc_sync_partner partner (.ref_clk_in(clk), .fire_in(fire), .polarity_in(pol),
        .sync_output_in(so), .sync_output_oe_in(soe), .sync_pin_out(pin),
        .pulses_out(pulses));
    function logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task chk_bit(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chk_bit
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task ctl(input logic [15:0] d);
        wr_reg(`PTBC_ADDR_CTRL, d);
        ctrl_m = d & `PTBC_CTRL_WMASK;
    endtask : ctl
    task cfg(input logic [15:0] c, input logic [2:0] dv, input logic [15:0] per);
        ctl(16'h0000);
        wr_reg(`PTBC_ADDR_DIV, {13'h0000, dv});
        wr_reg(`PTBC_ADDR_PER, per);
        ctl(c);
    endtask : cfg
    task wait_n(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : wait_n
    // Returns the cycles until the next boundary pulse; when none came, -1 if a miss is allowed, else the run fails and stops.
    task wait_start(input int lim, input bit may_miss, output int w);
        w = -1;
        for (int i = 1; i <= lim && w < 0; i++) begin
            @(posedge clk);
            #1 if (cs === 1'b1) w = i;
        end
        if (w < 0 && !may_miss) begin
            chk(16'h0000, 16'h0001);
            report_and_stop();
        end
    endtask : wait_start
    initial begin
        #3600000;
        chk(16'h0000, 16'h0001);
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(`PTBC_ADDR_CTRL, v);
        chk(v, 16'h0000);
        rd_reg(`PTBC_ADDR_DIV, v);
        chk(v, 16'h0000);
        wr_reg(`PTBC_ADDR_DIV, 16'hFFFF);
        rd_reg(`PTBC_ADDR_DIV, v);
        chk(v, 16'h0007);
        rd_reg(4'hF, v);
        chk(v, 16'h0000);
        wr_reg(`PTBC_ADDR_SEV, 16'hFFFF);
        ctl(16'h7FFF);
        rd_reg(`PTBC_ADDR_CTRL, v);
        chk(v, ctrl_m);
        wait_n(20);
        chk(cnt, 16'h0000);
        chk_bit(men, 1'b0);
        chk_bit(soe, 1'b1);
        chk_bit(so, 1'b1);
        for (k = 0; k < 4; k++) begin
            cfg({k != 0, 1'b0, k[0] ^ k[1], 13'h0000}, 3'h0, 16'h00C8);
            @(posedge clk);
            idle <= k[0];
            wait_n(3);
            p0 = cnt;
            wait_n(10);
            chk(cnt - p0, k < 2 ? 16'h0000 : 16'h000A);
        end
        idle <= 1'b0;
        for (n = 0; n < 8; n++) begin
            seed = xs(seed);
            p = 3 + int'(seed % 6);
            cfg(16'h8000, n[2:0], p[15:0]);
            wait_start(1200, n == 7, k);
            if (n < 7) wait_start(1200, 1'b0, k);
            chk(k[15:0], n == 7 ? 16'hFFFF : 16'((p + 1) << n));
        end
        for (n = 0; n < 2; n++) begin
            cfg(n ? 16'h8400 : 16'h8000, 3'h0, 16'h0014);
            wait_start(100, 1'b0, k);
            wr_reg(`PTBC_ADDR_PER, n ? 16'h001E : 16'h0003);
            wait_start(100, 1'b0, k);
            chk(16'(k + 2), n ? 16'h001F : 16'h0015);
            wait_start(100, 1'b0, k);
            chk(k[15:0], n ? 16'h001F : 16'h0004);
        end
        for (n = 0; n < 2; n++) begin
            rd_reg(`PTBC_ADDR_STAT, v);
            wr_reg(`PTBC_ADDR_MASK, n ? 16'h0002 : 16'h0000);
            cfg(n ? 16'h8800 : 16'h8000, 3'h0, 16'h0003);
            wr_reg(`PTBC_ADDR_SEV, 16'h0002);
            wait_n(20);
            wr_reg(`PTBC_ADDR_SEV, 16'hFFFF);
            ctl(ctrl_m & 16'h7FFF);
            wait_n(3);
            rd_reg(`PTBC_ADDR_CTRL, v);
            chk(v, ctrl_m | 16'h1000);
            chk_bit(se_irq, n[0]);
            chk_bit(irq, n[0]);
            rd_reg(`PTBC_ADDR_STAT, v);
            chk(v, 16'h0003);
            wait_n(2);
            chk_bit(irq, 1'b0);
            @(posedge clk);
            ack <= 1'b1;
            @(posedge clk);
            ack <= 1'b0;
            wait_n(2);
            rd_reg(`PTBC_ADDR_CTRL, v);
            chk(v, ctrl_m);
            chk_bit(se_irq, 1'b0);
        end
        for (n = 0; n < 4; n++) begin
            v = (n[0] ? 16'h0200 : 16'h0000) | (n[1] ? 16'h0180 : 16'h0000);
            cfg(v, 3'h0, 16'h00C8);
            @(posedge clk);
            pol <= n[0];
            wait_n(8);
            s0 = starts;
            p0 = pulses;
            ctl(v | 16'h8000);
            wait_n(2);
            chk_bit(soe, n[1]);
            chk_bit(men, 1'b1);
            wait_start(300, 1'b0, k);
            wait_n(20);
            chk_bit(so, n[0]);
            // The period stays far above the spacing of the sync pulses.
            @(posedge clk);
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            wait_start(10, 1'b1, k);
            chk_bit(k >= 0, n[1]);
            ctl(v);
            wait_n(4);
            chk(pulses - p0, n[1] ? 16'(starts - s0) : 16'h0000);
            rd_reg(`PTBC_ADDR_STAT, v);
            chk(v & 16'h0004, n[1] ? 16'h0004 : 16'h0000);
        end
        report_and_stop();
    end
endmodule : ptbc_tb_top
`default_nettype wire
